// [indirect_access_defines.vh]
`ifndef INDIRECT_ACCESS_DEFINES_VH
`define INDIRECT_ACCESS_DEFINES_VH

// Bridge register space offsets
`define IA_OFF_DATA 8'h10
`define IA_OFF_CMD 8'h14

// Command word fields
`define IA_OP_HI 31
`define IA_OP_LO 28
`define IA_SEL_BIT 26
`define IA_SIZE_BIT 27
`define IA_ADDR_HI 19
`define IA_OP_IO_WRITE 4'h1
`define IA_OP_IO_READ 4'h2
`define IA_OP_MMIO_WRITE 4'h4
`define IA_OP_MMIO_READ 4'h8

// Local addresses held inside the block
`define IA_LOC_PWB 20'h01C80
`define IA_LOC_WRB 20'hCDE02
`define IA_LOC_WWO 20'hCDE04
`define IA_LOC_WWC 20'hCDE06

// Private window base fields
`define IA_PWB_FIXED_HI 4'h1
`define IA_PWB_BOOTMAP_BIT 9
`define IA_PWB_HOLD_BIT 8
`define IA_PWB_WDOG_BIT 7
`define IA_PWB_PAGE_HI 6
`define IA_PAGE_INIT_NOROM 7'h00
`define IA_PAGE_INIT_BOOT 7'h70

// Window bound reset value and forced-zero bit
`define IA_BOUND_RESET 16'h0000
`define IA_BOUND_ZERO_BIT 8

// Attention bit that suppresses the access interrupt
`define IA_ATTN_NOIRQ_BIT 6

`endif

// [window_bound_regs.v]
`timescale 1ns/1ps
`default_nettype none
`include "indirect_access_defines.vh"

module window_bound_regs (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Core processor load port
  input wire boundWr,
  input wire [1:0] boundSel,
  input wire [15:0] boundData,
  // Readback select
  input wire [1:0] rdSel,
  output reg [15:0] rdValue,
  // Write permission check
  input wire [15:0] chkAddr,
  input wire writeAll,
  output reg chkAllow_r
);

  wire [15:0] stored [0:2];
  wire [15:0] natural [0:2];
  genvar g;

  // Bound storage, bit 8 held at zero; stored value is byte-swapped
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gBound
      reg [15:0] bound_r;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          bound_r <= `IA_BOUND_RESET;
        else if (boundWr && {30'h0, boundSel} == g)
          bound_r <= boundData & ~(16'h0001 << `IA_BOUND_ZERO_BIT); // [R20]
      end
      assign stored[g] = bound_r;
      // Low address byte sits in [15:8], high byte in [7:0]
      assign natural[g] = {bound_r[7:0], bound_r[15:8]}; // [R18]
    end
  endgenerate

  // Readback mux: 0 base, 1 open, 2 close
  always @*
  begin
    case (rdSel)
      2'h0: rdValue = stored[0];
      2'h1: rdValue = stored[1];
      2'h2: rdValue = stored[2];
      default: rdValue = 16'h0000;
    endcase
  end

  // Permission: below close, at or above open or region base; override all
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      chkAllow_r <= 1'b0;
    else
      chkAllow_r <= writeAll // [R24]
        || (chkAddr < natural[2] // [R21]
        && (chkAddr >= natural[1] || chkAddr >= natural[0])); // [R22] [R17]
  end

endmodule // window_bound_regs
`default_nettype wire

// [indirect_local_access_port.v]
`timescale 1ns/1ps
`default_nettype none
`include "indirect_access_defines.vh"

// Summary of operation
// R1: I/O write command has 0001 in bits 31:28, then the size bit.
// R2: I/O commands drive command bits 19:0 onto the local address bus; the code drives bits 15:0 and holds 19:16 at zero.
// R3: Host writes the command first, then the data word that performs it.
// R4: Host uses only 8 or 16 bit data accesses, never 24 or 32.
// R5: Host matches byte or word commands to each local register's width.
// R6: A 16-bit read/write data register sits at offset 10.
// R7: Data access opposite to the command's direction answers with target abort.
// R8: Data read answers retry until the local read data has arrived.
// R9: Byte reads return data in bits 7:0 whatever the address parity.
// R10: Byte writes take data from bits 7:0; the upper byte is ignored.
// R11: Private window base at 1C80h; bits 15:12 read 0001, bits 1:0 zero.
// R12: Bit 11 maps boot code; set when ROM fitted and remote boot wanted.
// R13: Bit 10 holds core processor in reset when no ROM is fitted.
// R14: Bit 9 disables the watchdog timer; cleared by default.
// R15: Bits 8:2 select private page; 00h without ROM, 1C0h for boot.
// R16: Boot code returns the page select to 00h before normal operation.
// R17: Read-only region base at CDE02h; writes allowed from it to window top.
// R18: Bound registers hold low address byte in 15:8, high byte in 7:0.
// R19: Host write to a bound register raises access interrupt unless attention bit 6.
// R20: Bit 8 of each bound register reads as zero.
// R21: Close bound at CDE06h is the first non-writable offset.
// R22: Open bound at CDE04h is the first writable address.
// R23: Command bit 27 selects byte (0) or word (1) access.
// R24: Shared memory write-all bit overrides the write window bounds.
module indirect_local_access_port (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Board straps
  input wire flashFitted,
  input wire remoteBoot,
  // Host register access
  input wire hostReq,
  input wire hostWrite,
  input wire [7:0] hostOffset,
  input wire [3:0] hostBe,
  input wire [31:0] hostWdata,
  output reg hostDone_r,
  output reg hostRetry_r,
  output reg hostAbort_r,
  output reg [31:0] hostRdata_r,
  // Local bus
  output reg [19:0] localAddr_r,
  output reg [15:0] localWdata_r,
  output reg localByte_r,
  output reg localWr_r,
  output reg localRd_r,
  input wire [15:0] localRdata,
  input wire localRdValid,
  // Core processor side
  input wire [7:0] coreProcAttention,
  input wire sharedMemWriteAll,
  input wire boundWr,
  input wire [1:0] boundSel,
  input wire [15:0] boundData,
  input wire [15:0] memChkAddr,
  output wire memWrAllow_r,
  output reg accessIrq_r,
  // Private window base controls
  output wire bootRomMapEn_r,
  output wire coreProcHold_r,
  output wire watchdogDisable_r,
  output wire [6:0] privatePageSelect_r
);

  // Read sequencing states, one-hot
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_HAVE = 3'h4;

  reg rstMeta_r;
  reg rst_r;
  reg strapDone_r;
  reg [31:0] cmd_r;
  reg [15:0] data_r;
  reg [9:0] pwb_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  // Decoded command and host strobes
  wire [3:0] access_a;
  wire isByte;
  wire [19:0] locAddr;
  wire cmdIoWr;
  wire cmdIoRd;
  wire cmdMmWr;
  wire cmdMmRd;
  wire cmdIsWr;
  wire cmdIsRd;
  wire hitPwb;
  wire hitBound;
  wire [1:0] boundIdx;
  wire [15:0] boundValue;
  wire [15:0] pwbFull;
  wire [15:0] byteSrc;
  wire [2:0] beCount;
  wire dataWr;
  wire dataRd;
  wire cmdWr;
  wire tooWide;
  wire [15:0] wrWord;

  // Reset release through two flops
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta_r <= 1'b0;
      rst_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rst_r <= rstMeta_r;
    end
  end

  // Command decode
  assign access_a = cmd_r[`IA_OP_HI:`IA_OP_LO];
  assign isByte = ~cmd_r[`IA_SIZE_BIT]; // [R23]
  assign locAddr = cmd_r[`IA_ADDR_HI:0];
  assign cmdIoWr = (access_a == `IA_OP_IO_WRITE); // [R1]
  assign cmdIoRd = (access_a == `IA_OP_IO_READ);
  assign cmdMmWr = (access_a == `IA_OP_MMIO_WRITE) && !cmd_r[`IA_SEL_BIT];
  assign cmdMmRd = (access_a == `IA_OP_MMIO_READ) && !cmd_r[`IA_SEL_BIT];
  assign cmdIsWr = cmdIoWr || cmdMmWr;
  assign cmdIsRd = cmdIoRd || cmdMmRd;

  // Local targets kept inside the block
  assign hitPwb = (cmdIoWr || cmdIoRd) && ({4'h0, locAddr[15:1], 1'h0} == `IA_LOC_PWB); // [R2]
  assign hitBound = (cmdMmWr || cmdMmRd)
    && (locAddr == `IA_LOC_WRB || locAddr == `IA_LOC_WWO || locAddr == `IA_LOC_WWC);
  assign boundIdx = locAddr[2:1] - 2'h1;

  // Private window base as seen by software
  assign pwbFull = {`IA_PWB_FIXED_HI, pwb_r, 2'h0}; // [R11]
  assign bootRomMapEn_r = pwb_r[`IA_PWB_BOOTMAP_BIT]; // [R12]
  assign coreProcHold_r = pwb_r[`IA_PWB_HOLD_BIT]; // [R13]
  assign watchdogDisable_r = pwb_r[`IA_PWB_WDOG_BIT]; // [R14]
  assign privatePageSelect_r = pwb_r[`IA_PWB_PAGE_HI:0]; // [R15]

  // Host strobe decode
  assign dataWr = hostReq && hostWrite && hostOffset == `IA_OFF_DATA;
  assign dataRd = hostReq && !hostWrite && hostOffset == `IA_OFF_DATA;
  assign cmdWr = hostReq && hostWrite && hostOffset == `IA_OFF_CMD;
  assign beCount = {2'h0, hostBe[0]} + {2'h0, hostBe[1]}
    + {2'h0, hostBe[2]} + {2'h0, hostBe[3]};
  assign tooWide = beCount > 3'h2; // [R4]

  // Byte writes take only bits 7:0
  assign wrWord = isByte ? {8'h00, hostWdata[7:0]} : hostWdata[15:0]; // [R10]

  // Byte reads land in bits 7:0, upper byte returned as zero
  assign byteSrc = hitPwb ? pwbFull : boundValue;

  window_bound_regs uBounds (
    .clk(clk),
    .rst_n(rst_r),
    .boundWr(boundWr),
    .boundSel(boundSel),
    .boundData(boundData),
    .rdSel(boundIdx),
    .rdValue(boundValue),
    .chkAddr(memChkAddr),
    .writeAll(sharedMemWriteAll),
    .chkAllow_r(memWrAllow_r)
  );

  // Command register, byte-enabled host writes
  always @(posedge clk or negedge rst_r)
  begin
    if (!rst_r)
      cmd_r <= 32'h00000000;
    else if (cmdWr)
    begin
      if (hostBe[0]) cmd_r[7:0] <= hostWdata[7:0];
      if (hostBe[1]) cmd_r[15:8] <= hostWdata[15:8];
      if (hostBe[2]) cmd_r[23:16] <= hostWdata[23:16];
      if (hostBe[3]) cmd_r[31:24] <= hostWdata[31:24];
    end
  end

  // Private window base: strap load after reset, then I/O writes
  always @(posedge clk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      strapDone_r <= 1'b0;
      pwb_r <= 10'h000;
    end
    else if (!strapDone_r)
    begin
      strapDone_r <= 1'b1;
      pwb_r[`IA_PWB_BOOTMAP_BIT] <= flashFitted && remoteBoot; // [R12]
      pwb_r[`IA_PWB_HOLD_BIT] <= !flashFitted; // [R13]
      pwb_r[`IA_PWB_WDOG_BIT] <= 1'b0; // [R14]
      pwb_r[`IA_PWB_PAGE_HI:0] <= (flashFitted && remoteBoot)
        ? `IA_PAGE_INIT_BOOT : `IA_PAGE_INIT_NOROM; // [R15]
    end
    else if (dataWr && cmdIoWr && hitPwb && !tooWide)
    begin
      if (!isByte)
        pwb_r <= wrWord[11:2];
      else if (!locAddr[0])
        pwb_r[5:0] <= wrWord[7:2];
      else
        pwb_r[9:6] <= wrWord[3:0];
    end
  end

  // Data register holds the last word moved either way
  always @(posedge clk or negedge rst_r)
  begin
    if (!rst_r)
      data_r <= 16'h0000;
    else if (dataWr && cmdIsWr && !tooWide)
      data_r <= wrWord; // [R6]
    else if (state_r == ST_WAIT && localRdValid)
      data_r <= isByte ? {8'h00, localRdata[7:0]} : localRdata; // [R9]
    else if (dataRd && cmdIsRd && (hitPwb || hitBound))
    begin
      if (!isByte)
        data_r <= byteSrc;
      else if (locAddr[0])
        data_r <= {8'h00, byteSrc[15:8]}; // [R9]
      else
        data_r <= {8'h00, byteSrc[7:0]}; // [R9]
    end
  end

  // Read sequencing for slow local reads
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (dataRd && cmdIsRd && !hitPwb && !hitBound && !tooWide)
          state_nxt = ST_WAIT;
      ST_WAIT:
        if (localRdValid)
          state_nxt = ST_HAVE;
      ST_HAVE:
        if (dataRd)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
    if (cmdWr)
      state_nxt = ST_IDLE;
  end

  // State register
  always @(posedge clk or negedge rst_r)
  begin
    if (!rst_r)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Local bus strobes and address
  always @(posedge clk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      localAddr_r <= 20'h00000;
      localWdata_r <= 16'h0000;
      localByte_r <= 1'b0;
      localWr_r <= 1'b0;
      localRd_r <= 1'b0;
    end
    else
    begin
      localWr_r <= dataWr && cmdIsWr && !hitPwb && !hitBound && !tooWide; // [R3]
      localRd_r <= dataRd && cmdIsRd && !hitPwb && !hitBound && !tooWide
        && state_r == ST_IDLE;
      // Address and data follow every data access
      if (dataWr || dataRd)
      begin
        localAddr_r <= cmdIoWr || cmdIoRd ? {4'h0, locAddr[15:0]} : locAddr; // [R2]
        localWdata_r <= wrWord;
        localByte_r <= isByte; // [R23]
      end
    end
  end

  // Host answers: done, retry or abort, one cycle after the request
  always @(posedge clk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      hostDone_r <= 1'b0;
      hostRetry_r <= 1'b0;
      hostAbort_r <= 1'b0;
      hostRdata_r <= 32'h00000000;
    end
    else
    begin
      hostDone_r <= 1'b0;
      hostRetry_r <= 1'b0;
      hostAbort_r <= 1'b0;
      if (hostReq)
      begin
        if ((dataRd && cmdIsWr) || (dataWr && cmdIsRd) || ((dataRd || dataWr) && tooWide))
          hostAbort_r <= 1'b1; // [R7]
        else if (dataRd && cmdIsRd && !hitPwb && !hitBound
          && state_r != ST_HAVE)
          hostRetry_r <= 1'b1; // [R8]
        else
          hostDone_r <= 1'b1;
        if (dataRd && state_r == ST_HAVE)
          hostRdata_r <= {16'h0000, data_r};
        else if (dataRd && (hitPwb || hitBound) && cmdIsRd)
          hostRdata_r <= isByte
            ? {24'h000000, locAddr[0] ? byteSrc[15:8] : byteSrc[7:0]} // [R9]
            : {16'h0000, byteSrc};
        else if (dataRd)
          hostRdata_r <= {16'h0000, data_r};
        else if (!hostWrite && hostOffset == `IA_OFF_CMD)
          hostRdata_r <= cmd_r;
        else
          hostRdata_r <= 32'h00000000;
      end
    end
  end

  // Host write to a bound register is dropped; flagged unless attention bit 6 is set
  always @(posedge clk or negedge rst_r)
  begin
    if (!rst_r)
      accessIrq_r <= 1'b0;
    else
      accessIrq_r <= dataWr && cmdMmWr && hitBound && !tooWide
        && !coreProcAttention[`IA_ATTN_NOIRQ_BIT]; // [R19]
  end

endmodule // indirect_local_access_port
`default_nettype wire

// [indirect_port_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module indirect_port_checker (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Requests
  input wire hostReq,
  input wire hostWrite,
  input wire [7:0] coreProcAttention,
  input wire sharedMemWriteAll,
  // Answers
  input wire hostDone_r,
  input wire hostRetry_r,
  input wire hostAbort_r,
  input wire [31:0] hostRdata_r,
  input wire localWr_r,
  input wire localRd_r,
  input wire localByte_r,
  input wire [15:0] localWdata_r,
  input wire memWrAllow_r,
  input wire accessIrq_r
);
  reg [1:0] upCnt_r;
  // Edges since release, covers the reset synchroniser
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
      upCnt_r <= 2'h0;
    else if (upCnt_r != 2'h3)
      upCnt_r <= upCnt_r + 2'h1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n || upCnt_r != 2'h3);
  answer_one_a: assert property (hostReq |=>
    $onehot({hostDone_r, hostRetry_r, hostAbort_r})) else $error("not one answer");
  no_stray_a: assert property (!hostReq |=>
    !(hostDone_r || hostRetry_r || hostAbort_r)) else $error("stray answer");
  abort_quiet_a: assert property (hostAbort_r |->
    !(localWr_r || localRd_r)) else $error("strobe on abort");
  write_strobe_a: assert property (localWr_r |->
    hostDone_r && $past(hostWrite)) else $error("bad write strobe");
  read_retry_a: assert property (localRd_r |->
    hostRetry_r && !$past(hostWrite)) else $error("read without retry");
  byte_low_a: assert property (localWr_r && localByte_r |->
    localWdata_r[15:8] == 8'h00) else $error("byte upper not zero");
  irq_mask_a: assert property (accessIrq_r |->
    hostDone_r && !$past(coreProcAttention[6])) else $error("bad access irq");
  write_all_a: assert property (sharedMemWriteAll |=>
    memWrAllow_r) else $error("write all ignored");
  rdata_hold_a: assert property (hostDone_r && !hostReq |=>
    $stable(hostRdata_r)) else $error("read data moved");
  cover property (hostRetry_r ##[1:12] hostDone_r);
  cover property (hostAbort_r);
  cover property (accessIrq_r);
endmodule // indirect_port_checker
bind indirect_local_access_port indirect_port_checker i_chk (.clk, .arst_n, .hostReq,
  .hostWrite, .coreProcAttention, .sharedMemWriteAll, .hostDone_r, .hostRetry_r,
  .hostAbort_r, .hostRdata_r, .localWr_r, .localRd_r, .localByte_r, .localWdata_r,
  .memWrAllow_r, .accessIrq_r);
`default_nettype wire

// [local_bus_responder.sv]
`timescale 1ns/1ps
`default_nettype none
module local_bus_responder (
  // Clock and local bus
  input wire clk,
  input wire localRd_r,
  input wire [19:0] localAddr_r,
  output reg [15:0] localRdata = 16'h0,
  output reg localRdValid = 1'h0,
  // Answer delay, at least one
  input wire [3:0] lag
);
  reg [3:0] waitCnt = 4'h0;
  reg [15:0] junk = 16'h5A3C;
  // Delayed answer; bus moves every cycle when idle
  always @(posedge clk)
  begin
    junk <= ~junk + 16'h1;
    localRdValid <= 1'h0;
    localRdata <= junk;
    if (localRd_r)
      waitCnt <= lag;
    else if (waitCnt != 4'h0)
    begin
      waitCnt <= waitCnt - 4'h1;
      if (waitCnt == 4'h1)
      begin
        localRdValid <= 1'h1;
        localRdata <= ~localAddr_r[15:0];
      end
    end
  end
endmodule // local_bus_responder
`default_nettype wire

// [indirect_local_access_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module indirect_local_access_port_tb_top;
  reg clk = 1'h0;
  reg arst_n = 1'h0;
  reg flashFitted = 1'h0;
  reg remoteBoot = 1'h0;
  reg hostReq = 1'h0;
  reg hostWrite = 1'h0;
  reg [7:0] hostOffset = 8'h00;
  reg [3:0] hostBe = 4'h0;
  reg [31:0] hostWdata = 32'h0;
  reg [7:0] coreProcAttention = 8'h00;
  reg sharedMemWriteAll = 1'h0;
  reg boundWr = 1'h0;
  reg [1:0] boundSel = 2'h0;
  reg [15:0] boundData = 16'h0;
  reg [15:0] memChkAddr = 16'h0;
  reg [3:0] lag = 4'h3;
  wire hostDone_r, hostRetry_r, hostAbort_r, localByte_r, localWr_r, localRd_r;
  wire localRdValid, memWrAllow_r, accessIrq_r, bootRomMapEn_r, coreProcHold_r;
  wire watchdogDisable_r;
  wire [31:0] hostRdata_r;
  wire [19:0] localAddr_r;
  wire [15:0] localWdata_r, localRdata;
  wire [6:0] privatePageSelect_r;
  integer fails = 0;
  integer checked = 0;
  reg [2:0] ans;
  reg [2:0] first;
  reg [31:0] got;
  reg lw;
  reg irq;
  reg rdStb;
  // Device and far-side local bus
  indirect_local_access_port i_dut (.clk, .arst_n, .flashFitted, .remoteBoot, .hostReq,
    .hostWrite, .hostOffset, .hostBe, .hostWdata, .hostDone_r, .hostRetry_r, .hostAbort_r,
    .hostRdata_r, .localAddr_r, .localWdata_r, .localByte_r, .localWr_r, .localRd_r,
    .localRdata, .localRdValid, .coreProcAttention, .sharedMemWriteAll, .boundWr,
    .boundSel, .boundData, .memChkAddr, .memWrAllow_r, .accessIrq_r, .bootRomMapEn_r,
    .coreProcHold_r, .watchdogDisable_r, .privatePageSelect_r);
  local_bus_responder i_far (.clk, .localRd_r, .localAddr_r, .localRdata, .localRdValid,
    .lag);
  // Clock
  initial
    forever #20 clk = ~clk;
  task chk(input [8*10:1] what, input [31:0] exp, input [31:0] seen);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("BAD %0s exp %h seen %h", what, exp, seen);
    end
  end
  endtask
  task close_out;
  begin
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task rst(input f, input b);
  begin
    arst_n = 1'h0;
    flashFitted = f;
    remoteBoot = b;
    repeat (10) @(posedge clk);
    #1 arst_n = 1'h1;
    repeat (4) @(posedge clk);
    #1;
  end
  endtask
  // One host access; answer sampled in the cycle after it is taken
  task acc(input w, input [7:0] off, input [3:0] be, input [31:0] wd);
  begin
    @(posedge clk);
    #1 hostReq = 1'h1;
    hostWrite = w;
    hostOffset = off;
    hostBe = be;
    hostWdata = wd;
    @(posedge clk);
    #1 hostReq = 1'h0;
    ans = {hostDone_r, hostRetry_r, hostAbort_r};
    got = hostRdata_r;
    lw = localWr_r;
    irq = accessIrq_r;
  end
  endtask
  task wr(input [31:0] cmd, input [31:0] d, input [3:0] be);
  begin
    acc(1'h1, 8'h14, 4'hF, cmd);
    acc(1'h1, 8'h10, be, d);
  end
  endtask
  task rd(input [31:0] cmd);
    integer n;
  begin
    acc(1'h1, 8'h14, 4'hF, cmd);
    acc(1'h0, 8'h10, 4'h3, 32'h0);
    first = ans;
    rdStb = localRd_r;
    for (n = 0; n < 12 && ans == 3'h2; n = n + 1)
      acc(1'h0, 8'h10, 4'h3, 32'h0);
  end
  endtask
  task bnd(input [1:0] s, input [15:0] d);
  begin
    @(posedge clk);
    #1 boundWr = 1'h1;
    boundSel = s;
    boundData = d;
    @(posedge clk);
    #1 boundWr = 1'h0;
  end
  endtask
  task allow(input [15:0] a, input e);
  begin
    memChkAddr = a;
    repeat (2) @(posedge clk);
    #1 chk("allow", e, memWrAllow_r);
  end
  endtask
  task t_base;
  begin
    rd(32'h28001C80);
    chk("base rst", 32'h1400, got);
    chk("no rd stb", 1'h0, rdStb);
    chk("hold", 1'h1, coreProcHold_r);
    chk("wdog", 1'h0, watchdogDisable_r);
    wr(32'h18001C80, 32'h0000FFFF, 4'h3);
    rd(32'h28001C80);
    chk("base all", 32'h1FFC, got);
    chk("wdog set", 1'h1, watchdogDisable_r);
    chk("page", 7'h7F, privatePageSelect_r);
    rd(32'h20001C81);
    chk("odd byte", 32'h1F, got);
    rd(32'h20001C80);
    chk("even byte", 32'hFC, got);
    wr(32'h18001C80, 32'h0, 4'h3);
    chk("page clr", 7'h00, privatePageSelect_r);
  end
  endtask
  task t_ext;
  begin
    wr(32'h1000180D, 32'h0000AB55, 4'h1);
    chk("strobe", 1'h1, lw);
    chk("laddr", 20'h0180D, localAddr_r);
    chk("lbyte", 1'h1, localByte_r);
    chk("ldata", 16'h0055, localWdata_r);
    rd(32'h28001C8A);
    chk("first", 3'h2, first);
    chk("rd strobe", 1'h1, rdStb);
    chk("raddr", 20'h01C8A, localAddr_r);
    chk("ext word", 32'hE375, got);
    lag = 4'h1;
    rd(32'h2000180D);
    chk("ext byte", 32'hF2, got);
  end
  endtask
  task t_abort;
  begin
    acc(1'h1, 8'h14, 4'hF, 32'h18001C8A);
    acc(1'h0, 8'h10, 4'h3, 32'h0);
    chk("rd on wr", 3'h1, ans);
    acc(1'h1, 8'h10, 4'hF, 32'h1234);
    chk("wide", 3'h1, ans);
    chk("no strobe", 1'h0, lw);
    acc(1'h1, 8'h14, 4'hF, 32'h28001C8A);
    acc(1'h1, 8'h10, 4'h3, 32'h0);
    chk("wr on rd", 3'h1, ans);
    acc(1'h0, 8'h14, 4'hF, 32'h0);
    chk("cmd rd", 32'h28001C8A, got);
    acc(1'h0, 8'h20, 4'hF, 32'h0);
    chk("unmapped", 3'h4, ans);
    chk("unmap rd", 32'h0, got);
  end
  endtask
  task t_bound;
  begin
    bnd(2'h0, 16'h00FF);
    bnd(2'h1, 16'h0101);
    bnd(2'h2, 16'h0002);
    rd(32'h880CDE04);
    chk("open rd", 32'h0001, got);
    allow(16'h00FF, 1'h0);
    allow(16'h0100, 1'h1);
    allow(16'h01FF, 1'h1);
    allow(16'h0200, 1'h0);
    sharedMemWriteAll = 1'h1;
    allow(16'h0200, 1'h1);
    sharedMemWriteAll = 1'h0;
    bnd(2'h0, 16'h8000);
    allow(16'h007F, 1'h0);
    allow(16'h0080, 1'h1);
    wr(32'h480CDE06, 32'h0000FFFF, 4'h3);
    chk("irq", 1'h1, irq);
    wr(32'h480CDE10, 32'h00001234, 4'h3);
    chk("irq off", 1'h0, irq);
    chk("mm strobe", 1'h1, lw);
    rd(32'h880CDE06);
    chk("close ro", 32'h0002, got);
    coreProcAttention = 8'h40;
    wr(32'h480CDE02, 32'h0000FFFF, 4'h3);
    chk("irq mask", 1'h0, irq);
  end
  endtask
  task t_boot;
  begin
    rst(1'h1, 1'h1);
    chk("map", 1'h1, bootRomMapEn_r);
    chk("hold rom", 1'h0, coreProcHold_r);
    rd(32'h28001C80);
    chk("base boot", 32'h19C0, got);
  end
  endtask
  // Main sequence
  initial
  begin
    rst(1'h0, 1'h0);
    t_base;
    t_ext;
    t_abort;
    t_bound;
    t_boot;
    close_out;
  end
  // Hang guard
  initial
  begin
    #100000;
    fails = fails + 1;
    close_out;
  end
endmodule // indirect_local_access_port_tb_top
`default_nettype wire
